// ---- rtl/cbc_pkg.sv ----
// Constants, types and bus-cycle codes for the processor bus control block.
// How it works
// - The non-maskable interrupt input is looked at only in the last clock cycle of an instruction.
// - A recognised non-maskable interrupt raises an interrupt of vector type 2 that software cannot mask.
// - In minimum mode the memory-or-IO output shows whether the bus cycle targets memory or an I/O device.
// - In minimum mode the write strobe times each write to memory or an I/O device.
// - In minimum mode the acknowledge strobe serves as the read strobe for the vector in an acknowledge cycle.
// - The address latch strobe pulses so an outside latch can capture the address from the shared bus.
// - In minimum mode the direction output tells the data buffer whether data flows in or out.
// - In minimum mode the buffer enable is asserted whenever the data buffer is to pass data.
// - A hold request makes the processor release the bus at the end of the current instruction.
// - Hold acknowledge rises only after the request was accepted and the bus was released.
// - The read strobe goes low to time reads from memory or an I/O port.
// - While ready is low wait states are inserted, and the transfer ends once ready is high.
package cbc_pkg;

    // ------------------------------------------------------------------
    // Bus cycle codes, equal to the maximum-mode status encoding
    // ------------------------------------------------------------------
    localparam logic [2:0] CYC_IRQ_ACK = 3'h0;
    localparam logic [2:0] CYC_IO_RD = 3'h1;
    localparam logic [2:0] CYC_IO_WR = 3'h2;
    localparam logic [2:0] CYC_HOLD = 3'h3;
    localparam logic [2:0] CYC_FETCH = 3'h4;
    localparam logic [2:0] CYC_MEM_RD = 3'h5;
    localparam logic [2:0] CYC_MEM_WR = 3'h6;
    localparam logic [2:0] CYC_PASSIVE = 3'h7;
    localparam int CYC_MEM_BIT = 2;

    localparam logic [7:0] NMI_VECTOR = 8'h02;
    localparam int RESET_MIN_CYCLES = 4;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {S_IDLE, S_T1, S_T2, S_T3, S_TW, S_T4, S_HOLD} cbc_bstate_t;

    typedef struct packed {
        logic [2:0] kind;
        logic [15:0] addr;
        logic [15:0] wdata;
    } cbc_req_t;

    typedef struct packed {
        logic nmi;
        logic ready;
        logic hold;
        logic max_mode;
        logic [15:0] ad;
    } cbc_pin_in_t;

    typedef struct packed {
        logic ale;
        logic rd_n;
        logic wr_n;
        logic irq_ack_strobe_n;
        logic mem_io;
        logic dt_r;
        logic buffer_enable_n;
        logic [2:0] cycle_status;
        logic ctl_oe;
        logic [15:0] ad;
        logic ad_oe;
        logic bus_grant_out;
    } cbc_pin_out_t;

    localparam cbc_pin_out_t PINS_IDLE = '{ale: 1'b0, rd_n: 1'b1, wr_n: 1'b1, irq_ack_strobe_n: 1'b1,
        mem_io: 1'b0, dt_r: 1'b0, buffer_enable_n: 1'b1, cycle_status: CYC_PASSIVE, ctl_oe: 1'b1,
        ad: 16'h0000, ad_oe: 1'b0, bus_grant_out: 1'b0};

    typedef struct packed {
        cbc_bstate_t st;
        cbc_req_t req;
        cbc_pin_in_t sync1;
        cbc_pin_in_t sync2;
        cbc_pin_out_t pins;
        logic [15:0] rdata;
        logic done;
        logic nmi_armed;
        logic nmi_take;
        logic hold_pend;
    } cbc_state_t;

endpackage

// ---- rtl/cbc_bus_ctrl.sv ----
// Bus control pin sequencer: bus cycles, strobes, status, hold handshake and NMI sampling.
`timescale 1ns/10ps
module cbc_bus_ctrl
    import cbc_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic i_instr_last,
    input wire logic i_req_valid,
    input wire cbc_req_t i_req,
    output logic o_req_ready,
    output logic [15:0] o_rdata,
    output logic o_done,
    output logic o_nmi_take,
    output logic [7:0] o_int_type,
    input wire cbc_pin_in_t i_pins,
    output cbc_pin_out_t o_pins
);

    // ------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------
    function automatic logic is_write(input logic [2:0] kind);
        return (kind == CYC_IO_WR) || (kind == CYC_MEM_WR);
    endfunction

    function automatic logic is_read(input logic [2:0] kind);
        return (kind == CYC_IO_RD) || (kind == CYC_MEM_RD) || (kind == CYC_FETCH);
    endfunction

    // Pin levels are a function of the next state and the current synchronised mode pin, so every pin leaves a flip-flop.
    function automatic cbc_pin_out_t drive_pins(input cbc_bstate_t st, input cbc_req_t rq, input logic maxm);
        cbc_pin_out_t p;
        logic strobe;
        p = PINS_IDLE;
        strobe = 1'b0;
        p.mem_io = rq.kind[CYC_MEM_BIT];
        p.dt_r = is_write(rq.kind);
        p.ad = rq.addr;
        case (st)
            S_T1:
            begin
                p.ale = 1'b1;
                p.ad_oe = (rq.kind != CYC_IRQ_ACK);
                p.cycle_status = maxm ? rq.kind : CYC_PASSIVE;
            end
            S_T2:
            begin
                strobe = 1'b1;
                p.cycle_status = maxm ? rq.kind : CYC_PASSIVE;
            end
            S_T3, S_TW:
            begin
                strobe = 1'b1;
            end
            S_T4:
            begin
                p.buffer_enable_n = maxm;
            end
            S_HOLD:
            begin
                // The bus is handed over: strobes and address/data float.
                p.ctl_oe = 1'b0;
                p.bus_grant_out = 1'b1;
            end
            default:
            begin
                p = PINS_IDLE;
            end
        endcase
        if (strobe)
        begin
            p.rd_n = !is_read(rq.kind);
            p.wr_n = !(is_write(rq.kind) && !maxm);
            p.irq_ack_strobe_n = !((rq.kind == CYC_IRQ_ACK) && !maxm);
            p.buffer_enable_n = maxm;
            p.ad = rq.wdata;
            p.ad_oe = is_write(rq.kind);
        end
        return p;
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    cbc_state_t q_ff;
    cbc_state_t nxt_q;

    always_comb
    begin
        nxt_q = q_ff;
        nxt_q.sync1 = i_pins;
        nxt_q.sync2 = q_ff.sync1;
        nxt_q.done = 1'b0;
        nxt_q.nmi_take = 1'b0;

        // A held-high NMI fires once; it must drop before it can be taken again.
        if (!q_ff.sync2.nmi)
        begin
            nxt_q.nmi_armed = 1'b1;
        end
        if (i_instr_last && q_ff.sync2.nmi && q_ff.nmi_armed)
        begin
            nxt_q.nmi_take = 1'b1;
            nxt_q.nmi_armed = 1'b0;
        end

        if (i_instr_last && q_ff.sync2.hold)
        begin
            nxt_q.hold_pend = 1'b1;
        end

        case (q_ff.st)
            S_IDLE:
            begin
                if (q_ff.hold_pend)
                begin
                    nxt_q.st = S_HOLD;
                end
                else if (i_req_valid)
                begin
                    nxt_q.st = S_T1;
                    nxt_q.req = i_req;
                end
            end
            S_T1:
            begin
                nxt_q.st = S_T2;
            end
            S_T2:
            begin
                nxt_q.st = S_T3;
            end
            S_T3, S_TW:
            begin
                nxt_q.st = q_ff.sync2.ready ? S_T4 : S_TW;
            end
            S_T4:
            begin
                nxt_q.st = S_IDLE;
                nxt_q.rdata = q_ff.sync2.ad;
                nxt_q.done = 1'b1;
            end
            S_HOLD:
            begin
                if (!q_ff.sync2.hold)
                begin
                    nxt_q.st = S_IDLE;
                    nxt_q.hold_pend = 1'b0;
                end
            end
            default:
            begin
                nxt_q.st = S_IDLE;
            end
        endcase
        nxt_q.pins = drive_pins(nxt_q.st, nxt_q.req, q_ff.sync2.max_mode);
    end

    // Reset is synchronous; the outside keeps it high for at least RESET_MIN_CYCLES clocks.
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            q_ff <= '{st: S_IDLE, pins: PINS_IDLE, default: '0};
        end
        else
        begin
            q_ff <= nxt_q;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign o_req_ready = (q_ff.st == S_IDLE) && !q_ff.hold_pend;
    assign o_rdata = q_ff.rdata;
    assign o_done = q_ff.done;
    assign o_nmi_take = q_ff.nmi_take;
    assign o_int_type = NMI_VECTOR;
    assign o_pins = q_ff.pins;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_nmi_last_cycle: assert property (@(posedge i_mclk) disable iff (i_srst)
        o_nmi_take |-> $past(i_instr_last) && $past(q_ff.sync2.nmi))
        else $error("NMI taken outside the last instruction cycle.");

    chk_nmi_vector_type: assert property (@(posedge i_mclk) disable iff (i_srst)
        (i_instr_last && q_ff.sync2.nmi && q_ff.nmi_armed) |=> o_nmi_take && (o_int_type == NMI_VECTOR))
        else $error("Recognised NMI did not raise type 2.");

    chk_mem_io_select: assert property (@(posedge i_mclk) disable iff (i_srst)
        o_pins.ale |-> (o_pins.mem_io == q_ff.req.kind[CYC_MEM_BIT]))
        else $error("Memory or IO select wrong at address time.");

    chk_wr_strobe_type: assert property (@(posedge i_mclk) disable iff (i_srst)
        !o_pins.wr_n |-> is_write(q_ff.req.kind) && !q_ff.sync2.max_mode && o_pins.ad_oe)
        else $error("Write strobe outside a driven write cycle.");

    chk_ack_strobe: assert property (@(posedge i_mclk) disable iff (i_srst)
        !o_pins.irq_ack_strobe_n |-> o_pins.rd_n && !o_pins.ad_oe && (q_ff.req.kind == CYC_IRQ_ACK))
        else $error("Acknowledge strobe misused.");

    chk_ale_one_pulse: assert property (@(posedge i_mclk) disable iff (i_srst)
        $rose(o_pins.ale) |-> o_pins.ad_oe || (q_ff.req.kind == CYC_IRQ_ACK) ##1 !o_pins.ale ##1 !o_pins.ale)
        else $error("Address latch strobe not a single pulse.");

    chk_dir_and_enable: assert property (@(posedge i_mclk) disable iff (i_srst)
        (!o_pins.rd_n || !o_pins.wr_n) && !q_ff.sync2.max_mode |-> !o_pins.buffer_enable_n
        && (o_pins.dt_r == !o_pins.wr_n))
        else $error("Buffer direction or enable wrong during a strobe.");

    chk_grant_release: assert property (@(posedge i_mclk) disable iff (i_srst)
        $rose(o_pins.bus_grant_out) |-> !o_pins.ad_oe && !o_pins.ctl_oe && $past(q_ff.hold_pend))
        else $error("Hold acknowledged before the bus was released.");

    chk_status_code: assert property (@(posedge i_mclk) disable iff (i_srst)
        o_pins.ale && q_ff.sync2.max_mode && $past(q_ff.sync2.max_mode) |-> o_pins.cycle_status == q_ff.req.kind)
        else $error("Maximum-mode status does not carry the cycle type.");

    chk_rd_strobe_type: assert property (@(posedge i_mclk) disable iff (i_srst)
        $fell(o_pins.rd_n) |-> is_read(q_ff.req.kind) && $past(o_pins.ale))
        else $error("Read strobe fell outside T2 of a read cycle.");

    chk_wait_states: assert property (@(posedge i_mclk) disable iff (i_srst)
        ((q_ff.st == S_T3) || (q_ff.st == S_TW)) && !q_ff.sync2.ready |=> (q_ff.st == S_TW) && !o_done)
        else $error("Cycle ended while ready was low.");

endmodule // cbc_bus_ctrl

// ---- testbench/cbc_bus_partner.sv ----
// Far-side model: memory, I/O ports and an interrupt controller on the shared bus.
`timescale 1ns/10ps
module cbc_bus_partner
    import cbc_pkg::*;
#(
    parameter logic [15:0] VEC = 16'h0042
)
(
    input wire logic i_mclk,
    input wire cbc_pin_out_t i_pins,
    input wire logic [3:0] i_waits,
    output logic o_ready,
    output logic [15:0] o_ad
);
    logic [15:0] mem_ff [16];
    logic [15:0] io_ff [16];
    logic [3:0] adr_ff = 4'h0;
    logic [3:0] wcnt_ff = 4'hF;
    logic [1:0] keep_ff = 2'h0;
    logic [15:0] last_ff = 16'h0000;
    logic sp_ff = 1'b0;
    logic ack_ff = 1'b0;
    logic drive;
    // -----------------------------------------------------------------
    // Replies
    // -----------------------------------------------------------------
    assign drive = !i_pins.rd_n || !i_pins.irq_ack_strobe_n || keep_ff != 2'h0;
    // Ready drops already in the address phase, since the sequencer sees it two clocks late.
    assign o_ready = i_waits == 4'h0 || (!i_pins.ale && wcnt_ff >= i_waits);
    // A released bus shows the inverse of the last value, never a stale copy.
    assign o_ad = !drive ? ~last_ff : (ack_ff || !i_pins.irq_ack_strobe_n) ? VEC
        : sp_ff ? mem_ff[adr_ff] : io_ff[adr_ff];
    always @(posedge i_mclk)
    begin
        last_ff <= o_ad;
        keep_ff <= (!i_pins.rd_n || !i_pins.irq_ack_strobe_n) ? 2'h3 : keep_ff - (keep_ff != 2'h0);
        if (!i_pins.irq_ack_strobe_n)
            ack_ff <= 1'b1;
        if (i_pins.ale)
        begin
            adr_ff <= i_pins.ad[3:0];
            sp_ff <= (i_pins.cycle_status != 3'h7) ? i_pins.cycle_status[2] : i_pins.mem_io;
            ack_ff <= 1'b0;
            wcnt_ff <= 4'h0;
        end
        else if (wcnt_ff != 4'hF)
            wcnt_ff <= wcnt_ff + 4'h1;
        if (!i_pins.wr_n && sp_ff)
            mem_ff[adr_ff] <= i_pins.ad;
        if (!i_pins.wr_n && !sp_ff)
            io_ff[adr_ff] <= i_pins.ad;
    end
endmodule // cbc_bus_partner

// ---- testbench/cbc_bus_ctrl_test.sv ----
// Self-checking bench for the bus control pin sequencer.
`timescale 1ns/10ps
module cbc_bus_ctrl_test
    import cbc_pkg::*;
;
    logic i_mclk = 0, i_srst = 1, i_instr_last = 0, i_req_valid = 0, nmi = 0, hold = 0, max_mode = 0;
    cbc_req_t i_req = '0;
    logic [3:0] waits = 4'h0;
    logic o_req_ready, o_done, o_nmi_take, p_ready;
    logic [15:0] o_rdata, p_ad;
    logic [7:0] o_int_type;
    cbc_pin_out_t o_pins;
    logic f_ale, f_rd, f_wr, f_ack, f_en, f_dtr;
    logic f_clr = 1'b0;
    logic [2:0] f_st;
    int n_mismatch = 0, n_checks = 0;
    always #4 i_mclk = ~i_mclk;
    cbc_bus_ctrl u_dut (.i_mclk(i_mclk), .i_srst(i_srst), .i_instr_last(i_instr_last), .i_req_valid(i_req_valid),
        .i_req(i_req), .o_req_ready(o_req_ready), .o_rdata(o_rdata), .o_done(o_done), .o_nmi_take(o_nmi_take),
        .o_int_type(o_int_type), .i_pins({nmi, p_ready, hold, max_mode, o_pins.ad_oe ? o_pins.ad : p_ad}),
        .o_pins(o_pins));
    cbc_bus_partner u_far (.i_mclk(i_mclk), .i_pins(o_pins), .i_waits(waits), .o_ready(p_ready), .o_ad(p_ad));
    always @(posedge i_mclk)
    begin
        f_st <= o_pins.ale ? o_pins.cycle_status : f_st;
        // The flags are cleared here only, so the bench has one driver for each.
        f_ale <= !f_clr && (f_ale || o_pins.ale);
        f_rd <= !f_clr && (f_rd || !o_pins.rd_n);
        f_wr <= !f_clr && (f_wr || !o_pins.wr_n);
        f_ack <= !f_clr && (f_ack || !o_pins.irq_ack_strobe_n);
        f_en <= !f_clr && (f_en || !o_pins.buffer_enable_n);
        f_dtr <= !f_clr && (f_dtr || o_pins.dt_r);
    end
    task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task wait_for(input int lim, input int t);
        if (t >= lim)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    endtask
    task op(input logic [2:0] k, input logic [15:0] a, input logic [15:0] w, output logic [15:0] rd, output int lat);
        int t;
        @(negedge i_mclk);
        f_clr = 1'b1;
        i_req = '{kind: k, addr: a, wdata: w};
        i_req_valid = 1;
        for (t = 0; o_req_ready !== 1'b1 && t < 50; t++)
            @(negedge i_mclk);
        wait_for(50, t);
        @(negedge i_mclk);
        i_req_valid = 0;
        f_clr = 1'b0;
        for (lat = 1; o_done !== 1'b1 && lat < 50; lat++)
            @(negedge i_mclk);
        wait_for(50, lat);
        rd = o_rdata;
    endtask
    task t_min;
        logic [15:0] r;
        int l;
        op(CYC_MEM_WR, 16'h0003, 16'hA55A, r, l);
        chk("write strobe", 1, f_wr);
        chk("direction write", 1, f_dtr);
        chk("latch pulse", 1, f_ale);
        chk("buffer enable", 1, f_en);
        chk("passive status", 16'h0007, {13'h0, f_st});
        op(CYC_IO_WR, 16'h0003, 16'h1234, r, l);
        op(CYC_MEM_RD, 16'h0003, 16'h0000, r, l);
        chk("memory read", 16'hA55A, r);
        chk("read strobe", 1, f_rd);
        chk("direction read", 0, f_dtr);
        chk("latency", 5, l);
        op(CYC_IO_RD, 16'h0003, 16'h0000, r, l);
        chk("io read", 16'h1234, r);
        op(CYC_IRQ_ACK, 16'h0000, 16'h0000, r, l);
        chk("vector", 16'h0042, r);
        chk("ack strobe", 1, f_ack);
        chk("no read strobe", 0, f_rd);
        $display("test min_mode done");
    endtask
    task t_max;
        logic [2:0] ks [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
        logic [15:0] r;
        int l;
        max_mode = 1;
        repeat (3) @(negedge i_mclk);
        foreach (ks[i])
        begin
            op(ks[i], 16'h0005, 16'h0F0F, r, l);
            chk("status code", {13'h0, ks[i]}, {13'h0, f_st});
            chk("no write strobe", 0, f_wr);
        end
        max_mode = 0;
        repeat (3) @(negedge i_mclk);
        waits = 4'h3;
        op(CYC_MEM_RD, 16'h0003, 16'h0000, r, l);
        chk("slow read", 16'hA55A, r);
        chk("waited", 1, l > 5);
        waits = 4'h0;
        $display("test max_mode_and_wait done");
    endtask
    task t_irq;
        int t;
        @(negedge i_mclk);
        nmi = 1;
        hold = 1;
        repeat (8)
        begin
            @(negedge i_mclk);
            chk("nmi early", 0, o_nmi_take);
            chk("grant early", 0, o_pins.bus_grant_out);
        end
        i_instr_last = 1;
        @(negedge i_mclk);
        i_instr_last = 0;
        for (t = 0; o_nmi_take !== 1'b1 && t < 4; t++)
            @(negedge i_mclk);
        wait_for(4, t);
        chk("nmi taken", 1, o_nmi_take);
        chk("vector type", 16'h0002, o_int_type);
        for (t = 0; o_pins.bus_grant_out !== 1'b1 && t < 6; t++)
            @(negedge i_mclk);
        wait_for(6, t);
        chk("grant", 1, o_pins.bus_grant_out);
        chk("strobes released", 0, o_pins.ctl_oe);
        chk("bus released", 0, o_pins.ad_oe);
        chk("requests held off", 0, o_req_ready);
        nmi = 0;
        hold = 0;
        for (t = 0; o_req_ready !== 1'b1 && t < 8; t++)
            @(negedge i_mclk);
        wait_for(8, t);
        chk("grant dropped", 0, o_pins.bus_grant_out);
        chk("bus back", 1, o_req_ready);
        $display("test nmi_and_hold done");
    endtask
    initial
    begin
        repeat (20) @(negedge i_mclk);
        i_srst = 0;
        chk("idle grant", 0, o_pins.bus_grant_out);
        t_min();
        t_max();
        t_irq();
        tally_and_finish();
    end
endmodule // cbc_bus_ctrl_test
